/* verilog/flash_seq_pkg.sv */
package flash_seq_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int PULSE_NS = 1000;
  localparam int ERASE_NS = 20000;
  localparam int POST_NS = 5000;
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC = (ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POST_CYC = (POST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 11;
  localparam logic [3:0] MAX_PULSES = 4'h8;

  // Register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_RDATA = 8'h10;
  localparam logic [7:0] OFF_ID = 8'h14;
  localparam logic [7:0] OFF_CFG = 8'h18;
  localparam logic [7:0] OFF_PROTECT = 8'h1c;

  // Command opcodes
  localparam logic [3:0] CMD_PROGRAM = 4'h1;
  localparam logic [3:0] CMD_SECTOR_ERASE = 4'h2;
  localparam logic [3:0] CMD_CHIP_ERASE = 4'h3;
  localparam logic [3:0] CMD_SUSPEND = 4'h4;
  localparam logic [3:0] CMD_RESUME = 4'h5;
  localparam logic [3:0] CMD_CLEAR_STATUS = 4'h6;

  // Status register bit positions
  localparam int ST_ACTIVE = 0;
  localparam int ST_PERR = 1;
  localparam int ST_EERR = 2;
  localparam int ST_ESUSP = 3;
  localparam int ST_PSUSP = 4;
  localparam int ST_REJECT = 5;

  // Data polling word bit positions
  localparam int POLL_ERR = 5;
  localparam int POLL_TOGGLE = 6;
  localparam int POLL_INV = 7;

  // Field positions and reset values
  localparam int CFG_PULSE_LSB = 0;
  localparam logic [3:0] CFG_PULSE_RST = 4'h2;
  localparam int ID_MFG_LSB = 0;
  localparam int ID_DEV_LSB = 8;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

/* verilog/flash_array_if.sv */
`timescale 1ns/100ps
interface flash_array_if #(
  parameter int AW = 6,
  parameter int NSEC = 4,
  parameter int DW = 16
);
  logic wrEn;
  logic [AW-1:0] wrAddr;
  logic [DW-1:0] wrData;
  logic ersEn;
  logic [NSEC-1:0] ersMask;
  logic [AW-1:0] rdAddrA;
  logic [AW-1:0] rdAddrB;
  logic [DW-1:0] rdDataA;
  logic [DW-1:0] rdDataB;

  modport sequencer (
    output wrEn, wrAddr, wrData, ersEn, ersMask, rdAddrA, rdAddrB,
    input rdDataA, rdDataB
  );
  modport array (
    input wrEn, wrAddr, wrData, ersEn, ersMask, rdAddrA, rdAddrB,
    output rdDataA, rdDataB
  );
endinterface

/* verilog/flash_cell_array.sv */
`timescale 1ns/100ps
module flash_cell_array
  import flash_seq_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int SECTOR_WORDS = 16,
  parameter int DATA_W = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  flash_array_if.array arr
);
  localparam int SW = $clog2(SECTOR_WORDS);

  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
  } cells_t;

  cells_t s;
  cells_t n;

  assign arr.rdDataA = s.mem[arr.rdAddrA];
  assign arr.rdDataB = s.mem[arr.rdAddrB];

  always_comb begin
    n = s;
    // Whole sectors return to ones at once
    for (int i = 0; i < DEPTH; i++) begin
      if (arr.ersEn && arr.ersMask[i >> SW]) begin
        n.mem[i] = '1;
      end
    end
    if (arr.wrEn) begin
      n.mem[arr.wrAddr] = arr.wrData;
    end
  end

  // Cells come up erased
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s <= '1;
    end else begin
      s <= n;
    end
  end
endmodule

/* verilog/nor_flash_op_sequencer.sv */
// Behaviour
// RULE_01: Erase can be suspended for reads, programs.
// RULE_02: Program can be suspended for reads.
// RULE_03: Other bank readable while one bank busy.
// RULE_04: Host waits after resume before suspending.
// RULE_05: Separate erase and program suspended flags.
// RULE_06: Host limits erases per location daily.
// RULE_07: Host reissues erase after power loss.
// RULE_08: Host rechecks errors seen while polling.
// RULE_09: Host checks status errors once ready.
// RULE_10: Host clears status error bits.
// RULE_11: Host spaces status polls apart.
// RULE_12: Host polls after every modifying operation.
// RULE_13: Program only clears bits, one to zero.
// RULE_14: Program repeats pulse then verify.
// RULE_15: Erase preprograms, bulk erases, then conditions.
// RULE_16: Active flag and program error flag.
// RULE_17: Active flag and erase error flag.
// RULE_18: Active flag shows command acceptance.
// RULE_19: Completion via polling, status, ready pin.
// RULE_20: Manufacturer and device identifiers readable.
// RULE_21: Busy bank takes only status or suspend.
`timescale 1ns/100ps
module nor_flash_op_sequencer
  import flash_seq_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int SECTOR_WORDS = 16,
  parameter int DATA_W = 16,
  // Identity values are arbitrary
  parameter logic [7:0] MFG_ID = 8'h5a,
  parameter logic [7:0] DEV_ID = 8'h3c
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic readyBusyPin
);
  localparam int AW = $clog2(DEPTH);
  localparam int SW = $clog2(SECTOR_WORDS);
  localparam int NSEC = DEPTH / SECTOR_WORDS;
  localparam int SECW = AW - SW;
  localparam int HALF = NSEC / 2;

  generate
    if (DEPTH != (1 << AW) || SECTOR_WORDS != (1 << SW) || NSEC < 2 ||
        NSEC > 32 || AW > 8 || DATA_W < 8 || DATA_W > 32) begin : g_bad
      $error("nor_flash_op_sequencer: unsupported geometry");
    end
  endgenerate

  typedef enum logic [2:0] {
    IDLE, PGM_PULSE, PGM_VERIFY, ERS_PRE, ERS_BULK, ERS_POST, SUSP
  } state_t;

  typedef struct packed {
    state_t state;
    state_t savedState;
    logic [AW-1:0] addr;
    logic [AW-1:0] opAddr;
    logic [AW-1:0] ersIdx;
    logic [AW-1:0] ersLast;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] target;
    logic [TIMER_W-1:0] timer;
    logic [3:0] pulseCnt;
    logic [3:0] pulseNeed;
    logic [NSEC-1:0] protect;
    logic [NSEC-1:0] ersMask;
    logic active;
    logic perr;
    logic eerr;
    logic esusp;
    logic psusp;
    logic reject;
    logic nested;
    logic pollToggle;
    logic awHave;
    logic [7:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic readyBusy;
  } regs_t;

  regs_t s;
  regs_t n;

  logic busyNow;
  logic wrFire;
  logic cmdValid;
  logic [3:0] cmdOp;
  logic took;
  logic [SECW-1:0] cmdSec;
  logic [NSEC-1:0] eraseMask;

  flash_array_if #(.AW(AW), .NSEC(NSEC), .DW(DATA_W)) arr();

  flash_cell_array #(
    .DEPTH(DEPTH),
    .SECTOR_WORDS(SECTOR_WORDS),
    .DATA_W(DATA_W)
  ) u_cells (
    .core_clk(core_clk),
    .nrst(nrst),
    .arr(arr.array)
  );

  function automatic logic [SECW-1:0] sectorOf(input logic [AW-1:0] a);
    return a[AW-1:SW];
  endfunction

  function automatic logic isPgm(input state_t st);
    return st == PGM_PULSE || st == PGM_VERIFY;
  endfunction

  function automatic logic isErs(input state_t st);
    return st == ERS_PRE || st == ERS_BULK || st == ERS_POST;
  endfunction

  // Bank counts as busy only while the running operation touches it
  function automatic logic bankBusy(input regs_t r, input logic bank);
    logic hit;
    hit = 1'b0;
    if (isPgm(r.state)) begin
      hit = r.opAddr[AW-1] == bank;
    end else if (isErs(r.state)) begin
      hit = bank ? |r.ersMask[NSEC-1:HALF] : |r.ersMask[HALF-1:0];
    end
    return hit;
  endfunction

  function automatic logic [31:0] statusWord(input regs_t r, input logic b);
    logic [31:0] w;
    w = 32'h0;
    w[ST_ACTIVE] = b;
    w[ST_PERR] = r.perr;
    w[ST_EERR] = r.eerr;
    w[ST_ESUSP] = r.esusp;
    w[ST_PSUSP] = r.psusp;
    w[ST_REJECT] = r.reject;
    return w;
  endfunction

  always_comb begin
    n = s;
    busyNow = s.active && s.state != SUSP;
    wrFire = s.awHave && s.wHave && !s.bvalid;
    cmdValid = 1'b0;
    cmdOp = s.wData[3:0];
    took = 1'b0;
    cmdSec = sectorOf(s.addr);
    eraseMask = '0;
    arr.wrEn = 1'b0;
    arr.wrAddr = s.opAddr;
    arr.wrData = s.target;
    arr.ersEn = 1'b0;
    arr.ersMask = s.ersMask;
    arr.rdAddrA = s.opAddr;
    arr.rdAddrB = s.addr;

    // Write channels are taken independently, in either order
    if (awvalid && s.awready) begin
      n.awHave = 1'b1;
      n.awAddr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.wHave = 1'b1;
      n.wData = wdata;
      n.wStrb = wstrb;
    end
    if (bready && s.bvalid) begin
      n.bvalid = 1'b0;
    end
    if (wrFire) begin
      n.awHave = 1'b0;
      n.wHave = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      unique case (s.awAddr)
        OFF_CMD: cmdValid = s.wStrb[0];
        OFF_ADDR: begin
          if (s.wStrb[0]) begin
            n.addr = s.wData[AW-1:0];
          end
        end
        OFF_WDATA: begin
          for (int b = 0; b < DATA_W / 8; b++) begin
            if (s.wStrb[b]) begin
              n.wdata[b*8 +: 8] = s.wData[b*8 +: 8];
            end
          end
        end
        OFF_STATUS: begin
          // Write one to clear; hardware sets below still win
          if (s.wStrb[0] && s.wData[ST_PERR]) begin
            n.perr = 1'b0;
          end
          if (s.wStrb[0] && s.wData[ST_EERR]) begin
            n.eerr = 1'b0;
          end
          if (s.wStrb[0] && s.wData[ST_REJECT]) begin
            n.reject = 1'b0;
          end
        end
        OFF_CFG: begin
          if (s.wStrb[0]) begin
            n.pulseNeed = s.wData[CFG_PULSE_LSB +: 4];
          end
        end
        OFF_PROTECT: begin
          if (s.wStrb[0]) begin
            n.protect = s.wData[NSEC-1:0];
          end
        end
        OFF_RDATA, OFF_ID: ;
        default: n.bresp = RESP_SLVERR;
      endcase
    end

    // Commands
    if (cmdValid) begin
      unique case (cmdOp)
        CMD_PROGRAM: begin
          // During erase suspend a program may go to a sector not erasing
          if (!s.active || (s.state == SUSP && s.esusp &&
              !s.ersMask[cmdSec])) begin // RULE_01
            if (s.protect[cmdSec]) begin
              n.perr = 1'b1; // RULE_16
            end else begin
              n.opAddr = s.addr;
              n.target = s.wdata;
              n.pulseCnt = 4'h0;
              n.timer = '0;
              n.nested = s.active;
              n.active = 1'b1; // RULE_18
              n.state = PGM_PULSE;
              took = 1'b1;
            end
          end else begin
            n.reject = 1'b1; // RULE_21
          end
        end
        CMD_SECTOR_ERASE, CMD_CHIP_ERASE: begin
          if (cmdOp == CMD_CHIP_ERASE) begin
            eraseMask = '1;
          end else begin
            eraseMask[cmdSec] = 1'b1; // RULE_15
          end
          if (s.active) begin
            n.reject = 1'b1; // RULE_21
          end else if (|(eraseMask & s.protect)) begin
            n.eerr = 1'b1; // RULE_17
          end else begin
            n.ersMask = eraseMask;
            n.ersIdx = (cmdOp == CMD_CHIP_ERASE) ? '0 : {cmdSec, {SW{1'b0}}};
            n.ersLast = (cmdOp == CMD_CHIP_ERASE) ? '1 : {cmdSec, {SW{1'b1}}};
            n.timer = '0;
            n.active = 1'b1; // RULE_18
            n.state = ERS_PRE;
            took = 1'b1;
          end
        end
        CMD_SUSPEND: begin
          if (busyNow && !s.nested && isPgm(s.state)) begin
            n.savedState = PGM_PULSE;
            n.psusp = 1'b1; // RULE_02 RULE_05
            n.state = SUSP;
            took = 1'b1;
          end else if (busyNow && isErs(s.state)) begin
            n.savedState = s.state;
            n.esusp = 1'b1; // RULE_01 RULE_05
            n.state = SUSP;
            took = 1'b1;
          end else begin
            n.reject = 1'b1;
          end
        end
        CMD_RESUME: begin
          // Phase timer restarts, so rapid suspends stall progress
          if (s.state == SUSP) begin
            n.state = s.savedState; // RULE_04
            n.psusp = 1'b0;
            n.esusp = 1'b0;
            n.timer = '0;
            took = 1'b1;
          end else begin
            n.reject = 1'b1;
          end
        end
        CMD_CLEAR_STATUS: begin
          n.perr = 1'b0;
          n.eerr = 1'b0;
          n.reject = 1'b0;
        end
        default: n.reject = 1'b1;
      endcase
    end

    // Embedded operation
    if (!took) begin
      unique case (s.state)
        IDLE, SUSP: ;
        PGM_PULSE: begin
          if (s.timer == TIMER_W'(PULSE_CYC - 1)) begin
            n.timer = '0;
            n.pulseCnt = s.pulseCnt + 4'h1;
            // Cell charges only after enough pulses
            if (s.pulseCnt + 4'h1 >= s.pulseNeed) begin
              arr.wrEn = 1'b1;
              arr.wrData = arr.rdDataA & s.target; // RULE_13
            end
            n.state = PGM_VERIFY; // RULE_14
          end else begin
            n.timer = s.timer + TIMER_W'(1);
          end
        end
        PGM_VERIFY: begin
          if ((arr.rdDataA & ~s.target) == '0 ||
              s.pulseCnt == MAX_PULSES) begin
            if ((arr.rdDataA & ~s.target) != '0) begin
              n.perr = 1'b1; // RULE_16
            end
            n.nested = 1'b0;
            n.active = s.nested;
            n.state = s.nested ? SUSP : IDLE;
          end else begin
            n.state = PGM_PULSE; // RULE_14
          end
        end
        ERS_PRE: begin
          arr.wrEn = 1'b1;
          arr.wrAddr = s.ersIdx;
          arr.wrData = '0; // RULE_15
          if (s.ersIdx == s.ersLast) begin
            n.state = ERS_BULK;
            n.timer = '0;
          end else begin
            n.ersIdx = s.ersIdx + AW'(1);
          end
        end
        ERS_BULK: begin
          if (s.timer == TIMER_W'(ERASE_CYC - 1)) begin
            arr.ersEn = 1'b1; // RULE_15
            n.timer = '0;
            n.state = ERS_POST;
          end else begin
            n.timer = s.timer + TIMER_W'(1);
          end
        end
        ERS_POST: begin
          if (s.timer == TIMER_W'(POST_CYC - 1)) begin
            n.active = 1'b0; // RULE_17
            n.ersMask = '0;
            n.state = IDLE;
          end else begin
            n.timer = s.timer + TIMER_W'(1);
          end
        end
      endcase
    end

    // Read channel
    if (rready && s.rvalid) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h0;
      unique case (araddr)
        OFF_CMD: ;
        OFF_ADDR: n.rdata[AW-1:0] = s.addr;
        OFF_WDATA: n.rdata[DATA_W-1:0] = s.wdata;
        OFF_STATUS: n.rdata = statusWord(s, busyNow); // RULE_19
        OFF_RDATA: begin
          if (bankBusy(s, s.addr[AW-1])) begin
            // Data polling word from the bank under operation
            n.rdata[POLL_INV] = isPgm(s.state) ? ~s.target[7] : 1'b0;
            n.rdata[POLL_TOGGLE] = s.pollToggle; // RULE_19
            n.rdata[POLL_ERR] = s.perr | s.eerr;
            n.pollToggle = ~s.pollToggle;
          end else begin
            n.rdata[DATA_W-1:0] = arr.rdDataB; // RULE_03
          end
        end
        OFF_ID: begin
          n.rdata[ID_MFG_LSB +: 8] = MFG_ID; // RULE_20
          n.rdata[ID_DEV_LSB +: 8] = DEV_ID;
        end
        OFF_CFG: n.rdata[CFG_PULSE_LSB +: 4] = s.pulseNeed;
        OFF_PROTECT: n.rdata[NSEC-1:0] = s.protect;
        default: n.rresp = RESP_SLVERR;
      endcase
    end

    n.awready = !n.awHave && !n.bvalid;
    n.wready = !n.wHave && !n.bvalid;
    n.arready = !n.rvalid;
    n.readyBusy = !(n.active && n.state != SUSP); // RULE_19
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s <= '0;
      s.pulseNeed <= CFG_PULSE_RST;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.readyBusy <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign readyBusyPin = s.readyBusy;
endmodule

/* dv/nor_flash_op_sequencer_asserts.sv */
`timescale 1ns/100ps
module nor_flash_op_sequencer_asserts
  import flash_seq_pkg::*;
#(
  parameter logic [7:0] MFG_ID = 8'h5a,
  parameter logic [7:0] DEV_ID = 8'h3c
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [7:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic readyBusyPin
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  a_bresp_hold: assert property (bvalid && !bready
    |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (rvalid && !rready
    |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_write_block: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_read_block: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
  a_read_lat: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_write_lat: assert property (awvalid && awready && wvalid && wready
    |=> !bvalid ##1 bvalid)
    else $error("write answer not two cycles after");
  a_id_value: assert property (arvalid && arready
    && araddr == OFF_ID
    |=> rdata == {16'h0, DEV_ID, MFG_ID} && rresp == RESP_OKAY)
    else $error("identifier word wrong");
  a_susp_flags: assert property (arvalid && arready
    && araddr == OFF_STATUS
    |=> !(rdata[ST_PSUSP] && (rdata[ST_ESUSP] || rdata[ST_ACTIVE])))
    else $error("suspend flags inconsistent");
  a_err_zero: assert property (rvalid && rresp == RESP_SLVERR
    |-> rdata == 32'h0)
    else $error("refused read returned data");
  a_reset_idle: assert property (@(posedge core_clk) disable iff (1'b0)
    !nrst |=> readyBusyPin && awready && arready && !bvalid && !rvalid)
    else $error("reset state wrong");
  c_busy: cover property ($fell(readyBusyPin));
  c_refused: cover property (bvalid && bresp == RESP_SLVERR);
  c_suspended: cover property (rvalid && rready && rdata[ST_ESUSP]);
endmodule

bind nor_flash_op_sequencer nor_flash_op_sequencer_asserts #(
  .MFG_ID(MFG_ID), .DEV_ID(DEV_ID)) chk_i (
  .core_clk(core_clk), .nrst(nrst), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
  .readyBusyPin(readyBusyPin));

/* dv/host_bus_model.sv */
`timescale 1ns/100ps
module host_bus_model (
  input wire logic core_clk,
  output logic awvalid,
  input wire logic awready,
  output logic [7:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  output logic arvalid,
  input wire logic arready,
  output logic [7:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  // Cycles to hold off accepting an answer, to act as a slow host
  int lag = 0;
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int k = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (lag == 0);
    forever begin
      @(posedge core_clk);
      // Released address and data lines show inverted junk, not the old value
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~awaddr;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~wdata;
      end
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
      k++;
      if (k >= lag) bready <= 1'b1;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int k = 0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (lag == 0);
    forever begin
      @(posedge core_clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~araddr;
      end
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
      k++;
      if (k >= lag) rready <= 1'b1;
    end
  endtask
endmodule

/* dv/nor_flash_op_sequencer_tb_top.sv */
`timescale 1ns/100ps
module nor_flash_op_sequencer_tb_top;
  import flash_seq_pkg::*;
  localparam logic [7:0] MFG = 8'h61; // Arbitrary identity value
  localparam logic [7:0] DEV = 8'h9e; // Arbitrary identity value
  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } row_t;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, readyBusyPin;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v1, v2;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  int nErrors = 0;
  int numChecks = 0;
  int n, n1, n3;
  row_t rows [8] = '{
    '{OFF_ADDR, 32'hffff_ffff, 32'h3f, RESP_OKAY},
    '{OFF_RDATA, 32'h0, 32'hffff, RESP_OKAY},
    '{OFF_WDATA, 32'h1234_abcd, 32'habcd, RESP_OKAY},
    '{OFF_PROTECT, 32'hf5, 32'h5, RESP_OKAY},
    '{OFF_PROTECT, 32'h0, 32'h0, RESP_OKAY},
    '{OFF_ID, 32'h0, {16'h0, DEV, MFG}, RESP_OKAY},
    '{8'h20, 32'h1, 32'h0, RESP_SLVERR},
    '{8'h06, 32'h1, 32'h0, RESP_SLVERR}};

  always #12.5 core_clk = ~core_clk;

  nor_flash_op_sequencer #(.MFG_ID(MFG), .DEV_ID(DEV)) dut (.*);
  host_bus_model m (.*);

  task automatic chk(input string nm, input logic [31:0] s, e);
    numChecks++;
    if (s !== e) begin
      nErrors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    m.wr(a, d, rs);
    chk("bresp", rs, RESP_OKAY);
  endtask
  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    m.rd(a, v1, rs);
    chk(nm, v1, e);
  endtask
  task automatic cmd(input logic [3:0] op);
    w(OFF_CMD, {28'h0, op});
  endtask
  // Bounded so a stuck busy pin cannot hang the run
  task automatic waitDone(output int c);
    c = 0;
    // Pin watch, not status reads, keeps polls sparse
    while (readyBusyPin !== 1'b1 && c < 5000) begin
      @(posedge core_clk);
      c++;
    end
    chk("ready wait", c < 5000, 1);
  endtask
  task automatic endOfTest;
    if (nErrors == 0 && numChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge core_clk);
    nErrors++;
    endOfTest;
  end

  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    rc("status", OFF_STATUS, 32'h0);
    rc("cfg", OFF_CFG, CFG_PULSE_RST);
    rc("protect", OFF_PROTECT, 32'h0);
    m.lag = 2;
    foreach (rows[i]) begin
      m.wr(rows[i].a, rows[i].d, rs);
      chk("row bresp", rs, rows[i].r);
      m.rd(rows[i].a, v1, rs);
      chk("row rresp", rs, rows[i].r);
      chk("row rdata", v1, rows[i].e);
    end
    m.lag = 0;
    // Span difference cancels the fixed bus overhead
    w(OFF_CFG, 1);
    w(OFF_ADDR, 32'h10);
    w(OFF_WDATA, 32'h0);
    cmd(CMD_PROGRAM);
    waitDone(n1);
    w(OFF_CFG, 3);
    w(OFF_ADDR, 32'h11);
    cmd(CMD_PROGRAM);
    waitDone(n3);
    chk("pulse span", n3 - n1, 2 * (PULSE_CYC + 1));
    w(OFF_CFG, 2);
    w(OFF_ADDR, 5);
    w(OFF_WDATA, 32'h0f0f);
    cmd(CMD_PROGRAM);
    rc("accepted", OFF_STATUS, 32'h1);
    chk("pin busy", readyBusyPin, 0);
    m.rd(OFF_RDATA, v1, rs);
    m.rd(OFF_RDATA, v2, rs);
    chk("poll inv", v1[POLL_INV], 1);
    chk("poll toggle", v1[POLL_TOGGLE] ^ v2[POLL_TOGGLE], 1);
    chk("poll err", v1[POLL_ERR], 0);
    waitDone(n);
    rc("done", OFF_STATUS, 32'h0);
    rc("word", OFF_RDATA, 32'h0f0f);
    w(OFF_WDATA, 32'hf0ff);
    cmd(CMD_PROGRAM);
    waitDone(n);
    rc("only clears", OFF_RDATA, 32'h000f);
    w(OFF_ADDR, 6);
    w(OFF_WDATA, 32'h1);
    cmd(CMD_PROGRAM);
    cmd(CMD_SUSPEND);
    rc("psusp", OFF_STATUS, 32'h10);
    chk("pin ready", readyBusyPin, 1);
    cmd(CMD_RESUME);
    rc("resumed", OFF_STATUS, 32'h1);
    waitDone(n);
    rc("resumed word", OFF_RDATA, 32'h1);
    w(OFF_ADDR, 5);
    cmd(CMD_SECTOR_ERASE);
    rc("erasing", OFF_STATUS, 32'h1);
    cmd(CMD_SUSPEND);
    rc("esusp", OFF_STATUS, 32'h8);
    w(OFF_ADDR, 32'h20);
    w(OFF_WDATA, 32'h1234);
    cmd(CMD_PROGRAM);
    rc("nested", OFF_STATUS, 32'h9);
    waitDone(n);
    rc("back", OFF_STATUS, 32'h8);
    // No suspend follows while this erase runs, so the resume gap is kept
    cmd(CMD_RESUME);
    rc("other bank", OFF_RDATA, 32'h1234);
    waitDone(n);
    w(OFF_ADDR, 5);
    rc("erased", OFF_RDATA, 32'hffff);
    w(OFF_ADDR, 32'h10);
    rc("sector only", OFF_RDATA, 32'h0);
    w(OFF_PROTECT, 1);
    w(OFF_ADDR, 3);
    cmd(CMD_SECTOR_ERASE);
    rc("eerr", OFF_STATUS, 32'h4);
    w(OFF_STATUS, 32'h4);
    rc("w1c", OFF_STATUS, 32'h0);
    cmd(CMD_PROGRAM);
    rc("perr", OFF_STATUS, 32'h2);
    cmd(CMD_CLEAR_STATUS);
    rc("cleared", OFF_STATUS, 32'h0);
    cmd(CMD_SUSPEND);
    rc("reject", OFF_STATUS, 32'h20);
    cmd(CMD_CLEAR_STATUS);
    w(OFF_PROTECT, 0);
    w(OFF_CFG, 9);
    w(OFF_ADDR, 32'h30);
    cmd(CMD_PROGRAM);
    waitDone(n);
    rc("pulse limit", OFF_STATUS, 32'h2);
    // Each sector sees only a few erases per run
    cmd(CMD_CHIP_ERASE);
    cmd(CMD_PROGRAM);
    rc("busy reject", OFF_STATUS, 32'h23);
    waitDone(n);
    w(OFF_ADDR, 32'h10);
    rc("chip erased", OFF_RDATA, 32'hffff);
    // Reset stands in for a power loss mid erase
    cmd(CMD_SECTOR_ERASE);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rc("reset status", OFF_STATUS, 32'h0);
    chk("reset pin", readyBusyPin, 1);
    w(OFF_ADDR, 32'h10);
    cmd(CMD_SECTOR_ERASE);
    rc("reissued", OFF_STATUS, 32'h1);
    waitDone(n);
    rc("reissue done", OFF_STATUS, 32'h0);
    endOfTest;
  end
endmodule
